// >>> core/bssd_decode.v
`include "bssd_defs.vh"
// Behaviour
// - top nibble 0101 sets selected bit of selected register, others unchanged
// - pattern 0110 bbbf ffff decodes as test-bit-skip-when-clear, f 0..31, b 0..7
// - skip next instruction only if selected bit reads zero
// - on skip, discard the prefetched instruction; it changes no state
// - a no-operation cycle executes in place of the discarded instruction
// - test instruction is one word, one cycle, two cycles when skipping
module bssd_decode
#(
   parameter DATA_W = `BSSD_DATA_W
)
(
   input  wire                    i_ref_clk,
   input  wire                    i_reset_n,
   input  wire                    i_instr_valid,
   input  wire [11:0]             i_instr,
   input  wire [DATA_W-1:0]       i_rf_rdata,
   output reg  [`BSSD_ADDR_W-1:0] o_rf_addr,
   output reg  [DATA_W-1:0]       o_rf_wdata,
   output reg                     o_rf_we,
   output reg                     o_skip,
   output reg                     o_nop_cycle,
   output reg                     o_status_we,
   output reg                     o_other_op
);
   // ****************************************
   // reset release
   // ****************************************
   reg rst_meta_r;
   reg rst_sync_r;

   // two-flop reset release
   always @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // ****************************************
   // state encoding and fields
   // ****************************************
   localparam ST_EXEC = 2'b01;
   localparam ST_NOP  = 2'b10;

   reg  [1:0]        state_r;
   reg  [1:0]        state_nxt;
   reg               rf_we_nxt;
   reg               skip_nxt;
   reg               nop_nxt;
   reg               other_nxt;
   wire [3:0]        opc   = i_instr[`BSSD_OPC_HI:`BSSD_OPC_LO];
   wire [2:0]        bsel  = i_instr[`BSSD_BIT_HI:`BSSD_BIT_LO];
   wire [4:0]        fsel  = i_instr[`BSSD_REG_HI:`BSSD_REG_LO];
   wire [DATA_W-1:0] set_data;
   wire              bit_val;
   wire              is_tst;
   wire              is_set;
   wire              skip_take;
   wire              in_slot;

   // ****************************************
   // helper functions
   // ****************************************
   // opcode match on a valid word
   function op_hit;
      input       valid;
      input [3:0] code;
      input [3:0] want;
      begin
         op_hit = valid && (code == want);
      end
   endfunction

   // ****************************************
   // opcode decode
   // ****************************************
   // test instruction decode
   assign is_tst    = op_hit(i_instr_valid, opc, `BSSD_OPC_TSTC);
   assign is_set    = op_hit(i_instr_valid, opc, `BSSD_OPC_SET);
   assign skip_take = is_tst && !bit_val;
   // word sits in the slot behind a taken skip
   assign in_slot   = (state_r == ST_NOP);

   // ****************************************
   // bit operations
   // ****************************************
   // bit set and bit pick on the read data
   bssd_bit_ops
   #(
      .DATA_W     (DATA_W)
   )
   i_bssd_bit_ops
   (
      .i_data     (i_rf_rdata),
      .i_bit_sel  (bsel),
      .o_set_data (set_data),
      .o_bit_val  (bit_val)
   );

   // ****************************************
   // slot sequencing
   // ****************************************
   // next state: nop slot after a taken skip
   always @*
   begin
      state_nxt = ST_EXEC;
      case (state_r)
         ST_EXEC:
         begin
            // second cycle only on a skip
            if (skip_take)
               state_nxt = ST_NOP;
         end
         ST_NOP:
            state_nxt = ST_EXEC;
         default:
            state_nxt = ST_EXEC;
      endcase
   end

   // slot state, idle until reset release ends
   always @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         state_r <= ST_EXEC;
      else if (!rst_sync_r)
         state_r <= ST_EXEC;
      else
         state_r <= state_nxt;
   end

   // ****************************************
   // execute strobes
   // ****************************************
   // next strobe values for the word on the bus
   always @*
   begin
      rf_we_nxt = 1'b0;
      skip_nxt  = 1'b0;
      nop_nxt   = 1'b0;
      other_nxt = 1'b0;
      if (!rst_sync_r)
      begin
         // quiet while reset release completes
         nop_nxt   = 1'b0;
      end
      else if (in_slot)
      begin
         rf_we_nxt = 1'b0;
         other_nxt = 1'b0;
         skip_nxt  = 1'b0;
         nop_nxt   = 1'b1;
      end
      else
      begin
         rf_we_nxt = is_set;
         skip_nxt  = skip_take;
         other_nxt = i_instr_valid && !is_set && !is_tst;
      end
   end

   // strobe registers, one cycle each
   always @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_rf_we     <= 1'b0;
         o_skip      <= 1'b0;
         o_nop_cycle <= 1'b0;
         o_other_op  <= 1'b0;
      end
      else
      begin
         o_rf_we     <= rf_we_nxt;
         o_skip      <= skip_nxt;
         o_nop_cycle <= nop_nxt;
         o_other_op  <= other_nxt;
      end
   end

   // ****************************************
   // write-back data
   // ****************************************
   // address and data follow every word on the bus once reset release ends, skipped words included
   always @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_rf_addr  <= `BSSD_ADDR_RST;
         o_rf_wdata <= {DATA_W{1'b0}};
      end
      else if (rst_sync_r)
      begin
         o_rf_addr  <= fsel;
         o_rf_wdata <= set_data;
      end
   end

   // ****************************************
   // status flags
   // ****************************************
   // status flags never written
   always @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_status_we <= 1'b0;
      else
         o_status_we <= 1'b0;
   end
endmodule // bssd_decode

// >>> core/bssd_defs.vh
`ifndef BSSD_DEFS_VH
`define BSSD_DEFS_VH
// ****************************************
// opcode fields
// ****************************************
`define BSSD_OP_W        12
`define BSSD_OPC_HI      11
`define BSSD_OPC_LO      8
`define BSSD_BIT_HI      7
`define BSSD_BIT_LO      5
`define BSSD_REG_HI      4
`define BSSD_REG_LO      0
`define BSSD_OPC_SET     4'h5
`define BSSD_OPC_TSTC    4'h6
`define BSSD_NOP_WORD    12'h000
`define BSSD_DATA_W      8
`define BSSD_ADDR_W      5
`define BSSD_ADDR_RST    5'h00
`endif

// >>> core/bssd_bit_ops.v
`include "bssd_defs.vh"
// ****************************************
// combinational bit set and bit pick
// ****************************************
module bssd_bit_ops
#(
   parameter DATA_W = `BSSD_DATA_W
)
(
   input  wire [DATA_W-1:0] i_data,
   input  wire [2:0]        i_bit_sel,
   output wire [DATA_W-1:0] o_set_data,
   output wire              o_bit_val
);
   // one-hot mask of the selected bit
   wire [DATA_W-1:0] mask = {{(DATA_W-1){1'b0}}, 1'b1} << i_bit_sel;

   // set forces the bit, pick reads it back
   assign o_set_data = i_data | mask;
   assign o_bit_val  = |(i_data & mask);
endmodule // bssd_bit_ops

// >>> tb/bssd_decode_assertions.sv
module bssd_chk
(
   input wire logic        i_ref_clk,
   input wire logic        i_reset_n,
   input wire logic        i_instr_valid,
   input wire logic [11:0] i_instr,
   input wire logic [7:0]  i_rf_rdata,
   input wire logic [7:0]  o_rf_wdata,
   input wire logic [4:0]  o_rf_addr,
   input wire logic        o_rf_we,
   input wire logic        o_skip,
   input wire logic        o_nop_cycle,
   input wire logic        o_status_we,
   input wire logic        o_other_op
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);
   // word executes unless it sits in a skip slot
   wire v = i_instr_valid && !o_skip;
   wire b = i_rf_rdata[i_instr[7:5]];
   set_write_a: assert property (v && i_instr[11:8] == 4'h5 |=> o_rf_we && o_rf_addr == $past(i_instr[4:0])
      && o_rf_wdata == ($past(i_rf_rdata) | (8'h01 << $past(i_instr[7:5])))) else $error("bad set");
   skip_clear_a: assert property (v && i_instr[11:8] == 4'h6 && !b |=> o_skip) else $error("no skip");
   test_no_write_a: assert property (v && i_instr[11:8] == 4'h6 |=> !o_rf_we && !o_other_op)
      else $error("test wrote");
   skip_set_a: assert property (v && i_instr[11:8] == 4'h6 && b |=> !o_skip ##1 !o_nop_cycle)
      else $error("bad skip");
   slot_discard_a: assert property (o_skip |=> !o_rf_we && !o_other_op) else $error("not discarded");
   nop_slot_a: assert property (o_skip |=> o_nop_cycle) else $error("no nop");
   nop_after_skip_a: assert property (o_nop_cycle |-> $past(o_skip)) else $error("stray nop");
   skip_once_a: assert property (o_skip |=> !o_skip) else $error("long skip");
   status_write_a: assert property (!o_status_we) else $error("flag write");
endmodule // bssd_chk

// >>> tb/test_bssd_decode.sv
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module test_bssd_decode;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_ref_clk = 0, i_reset_n = 0, i_instr_valid = 0;
   logic [11:0] i_instr = 12'h000;
   logic [7:0]  i_rf_rdata = 8'h00, o_rf_wdata;
   logic [4:0]  o_rf_addr;
   logic        o_rf_we, o_skip, o_nop_cycle, o_status_we, o_other_op;
   int          bad_count = 0, compares = 0, cyc = 0;
   bssd_decode i_bssd_decode
   (
      .i_ref_clk     (i_ref_clk),
      .i_reset_n     (i_reset_n),
      .i_instr_valid (i_instr_valid),
      .i_instr       (i_instr),
      .i_rf_rdata    (i_rf_rdata),
      .o_rf_addr     (o_rf_addr),
      .o_rf_wdata    (o_rf_wdata),
      .o_rf_we       (o_rf_we),
      .o_skip        (o_skip),
      .o_nop_cycle   (o_nop_cycle),
      .o_status_we   (o_status_we),
      .o_other_op    (o_other_op)
   );
   initial forever #50 i_ref_clk = ~i_ref_clk;
   // one word a cycle; ends with the previous word's outputs settled
   task put(input logic [11:0] w, input logic [7:0] d);
      @(posedge i_ref_clk);
      i_instr_valid <= 1'b1;
      i_instr <= w;
      i_rf_rdata <= d;
      #1;
   endtask
   task complete_run;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task t_set;
      put(12'h5e3, 8'h0a);
      put(12'h51f, 8'hfe);
      `CHK("wdata", 8'h8a, o_rf_wdata)
      `CHK("addr", 5'h03, o_rf_addr)
      `CHK("other", 1'b0, o_other_op)
      put(12'h000, 8'h00);
      `CHK("wdata", 8'hff, o_rf_wdata)
      `CHK("addr", 5'h1f, o_rf_addr)
      `CHK("we", 1'b1, o_rf_we)
      $display("set test ended");
   endtask
   task t_skip;
      put(12'h621, 8'hfd);
      `CHK("other", 1'b1, o_other_op)
      put(12'h5ff, 8'h00);
      `CHK("skip", 1'b1, o_skip)
      `CHK("other", 1'b0, o_other_op)
      put(12'h6e0, 8'h80);
      `CHK("nop", 1'b1, o_nop_cycle)
      `CHK("we", 1'b0, o_rf_we)
      `CHK("other", 1'b0, o_other_op)
      put(12'h5e3, 8'h0a);
      `CHK("skip", 1'b0, o_skip)
      `CHK("nop", 1'b0, o_nop_cycle)
      put(12'h000, 8'h00);
      `CHK("we", 1'b1, o_rf_we)
      `CHK("status", 1'b0, o_status_we)
      $display("skip test ended");
   endtask
   // a test word in the slot must not arm a second skip
   task t_slot_tst;
      put(12'h6ff, 8'h7f);
      put(12'h621, 8'h00);
      `CHK("skip", 1'b1, o_skip)
      `CHK("addr", 5'h1f, o_rf_addr)
      put(12'h51f, 8'h00);
      `CHK("skip", 1'b0, o_skip)
      `CHK("nop", 1'b1, o_nop_cycle)
      put(12'h000, 8'h00);
      `CHK("we", 1'b1, o_rf_we)
      `CHK("wdata", 8'h01, o_rf_wdata)
      `CHK("nop", 1'b0, o_nop_cycle)
      $display("slot test ended");
   endtask
   // reset in mid-run drops a pending skip
   task t_reset;
      put(12'h621, 8'hfd);
      @(posedge i_ref_clk);
      i_reset_n     <= 1'b0;
      i_instr_valid <= 1'b0;
      #1;
      `CHK("skip", 1'b0, o_skip)
      repeat (6) @(posedge i_ref_clk);
      i_reset_n <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      put(12'h5e3, 8'h0a);
      put(12'h000, 8'h00);
      `CHK("we", 1'b1, o_rf_we)
      `CHK("nop", 1'b0, o_nop_cycle)
      $display("reset test ended");
   endtask
   initial
   begin
      repeat (6) @(posedge i_ref_clk);
      i_reset_n <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      t_set;
      t_skip;
      t_slot_tst;
      t_reset;
      complete_run;
   end
   // hang guard
   always @(posedge i_ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 100)
      begin
         bad_count++;
         complete_run;
      end
   end
endmodule // test_bssd_decode
bind bssd_decode bssd_chk i_bssd_chk
(
   .i_ref_clk     (i_ref_clk),
   .i_reset_n     (i_reset_n),
   .i_instr_valid (i_instr_valid),
   .i_instr       (i_instr),
   .i_rf_rdata    (i_rf_rdata),
   .o_rf_wdata    (o_rf_wdata),
   .o_rf_addr     (o_rf_addr),
   .o_rf_we       (o_rf_we),
   .o_skip        (o_skip),
   .o_nop_cycle   (o_nop_cycle),
   .o_status_we   (o_status_we),
   .o_other_op    (o_other_op)
);
